// >>> art_regs.vh
// Register offsets, field positions, reset values and divider counts of the auto-reload timer.
`ifndef ART_REGS_VH
`define ART_REGS_VH

// ==========================================================================
// Register offsets on the special-function-register bus.
`define ART_OFS_CTRL 8'h91
`define ART_OFS_RELOAD_LO 8'h92
`define ART_OFS_RELOAD_HI 8'h93
`define ART_OFS_COUNT_LO 8'h94
`define ART_OFS_COUNT_HI 8'h95

// ==========================================================================
// Field positions inside timer_control.
`define ART_BIT_OVF 7
`define ART_BIT_RUN 2
`define ART_BIT_DIVSEL 1
`define ART_BIT_XCLK 0

// ==========================================================================
// Reset values.
`define ART_RST_CTRL 8'h00
`define ART_RST_FLAG 1'b0
`define ART_RST_RELOAD 16'h0000
`define ART_RST_COUNT 16'h0000

// ==========================================================================
// Divider counts and counter limits.
`define ART_SYS_DIV 4'hC
`define ART_XOSC_DIV 4'h8
`define ART_COUNT_MAX 16'hFFFF

`endif

// >>> art_xosc_tick.v
// External oscillator synchroniser and divide-by-eight tick generator.
`timescale 1ns/1ps

`include "art_regs.vh"

module art_xosc_tick (
    input wire clk_sys_i,
    input wire rst_b_i,
    input wire xosc_i,
    output reg tick_o
);

    // ======================================================================
    // Synchroniser.
    reg sync1_ff;
    reg sync2_ff;
    reg sync3_ff;
    reg level_ff;
    reg [3:0] edge_cnt_ff;
    reg [3:0] nxt_edge_cnt;
    reg nxt_level;
    reg nxt_tick;
    wire agree;

    // Three stages; a level change is accepted only when stages two and three agree.
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end else begin
            sync1_ff <= xosc_i;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    assign agree = (sync2_ff == sync3_ff);

    // ======================================================================
    // Divider.
    // Count accepted rising edges; every eighth one yields a single tick.
    // The oscillator must run well below half the system clock for this to hold.
    always @* begin
        nxt_level = level_ff;
        nxt_edge_cnt = edge_cnt_ff;
        nxt_tick = 1'b0;
        if (agree && (sync3_ff != level_ff)) begin
            nxt_level = sync3_ff;
            if (sync3_ff) begin
                if (edge_cnt_ff == (`ART_XOSC_DIV - 4'h1)) begin
                    nxt_edge_cnt = 4'h0;
                    nxt_tick = 1'b1;
                end else begin
                    nxt_edge_cnt = edge_cnt_ff + 4'h1;
                end
            end
        end
    end

    // Divider state.
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            level_ff <= 1'b0;
            edge_cnt_ff <= 4'h0;
            tick_o <= 1'b0;
        end else begin
            level_ff <= nxt_level;
            edge_cnt_ff <= nxt_edge_cnt;
            tick_o <= nxt_tick;
        end
    end

endmodule // art_xosc_tick

// >>> art_timer.v
// Sixteen-bit auto-reload timer with special-function-register access.
//
// Contract
// (R1) Sixteen-bit up-counter, low and high bytes readable and writable.
// (R2) External-clock select set: count external oscillator divided by eight.
// (R3) Otherwise count system clock divided by twelve, or undivided when selected.
// (R4) Always auto-reload: overflow loads the count from the reload bytes.
// (R5) Overflow from 0xFFFF to 0x0000 sets the overflow flag, bit 7.
// (R6) Flag set with interrupt enabled raises the interrupt request.
// (R7) Hardware never clears the flag; software clears it by writing control.
// (R8) Count only while run control bit 2 is one; otherwise hold.
// (R9) Control bits 6 to 3 read zero and ignore writes.
// (R10) No event counting from any external pin.
// (R11) Overflow event is an output for ADC start and SMBus timing.
// (R12) Oscillator-derived clock keeps counting regardless of system clock source.
// (R13) Oscillator increments are synchronised before software sees them.
// (R14) Reload happens on the flag-setting tick; reload writes act next overflow.
`timescale 1ns/1ps

`include "art_regs.vh"

module art_timer (
    input wire clk_sys_i,
    input wire rst_b_i,
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire [7:0] sfr_wdata_i,
    input wire sfr_rd_i,
    output reg [7:0] sfr_rdata_o,
    input wire irq_enable_i,
    input wire xosc_i,
    output reg irq_o,
    output reg overflow_pulse_o
);

    // ======================================================================
    // Declarations.
    reg overflow_flag_ff;
    reg run_control_ff;
    reg sysclk_divide_select_ff;
    reg external_clock_select_ff;
    reg [15:0] reload_ff;
    reg [15:0] count_ff;
    reg [3:0] div12_ff;
    reg [3:0] nxt_div12;
    reg sys_tick;
    reg timer_tick;
    reg rolls_over;
    reg [15:0] nxt_count;
    reg nxt_overflow_flag;
    reg [7:0] rd_mux;
    wire xosc_tick;
    wire wr_ctrl;
    wire wr_rl_lo;
    wire wr_rl_hi;
    wire wr_cnt_lo;
    wire wr_cnt_hi;

    // ======================================================================
    // Address decode.
    // Writes are single-cycle strobes qualified by the register offset.
    assign wr_ctrl = sfr_wr_i && (sfr_addr_i == `ART_OFS_CTRL);
    assign wr_rl_lo = sfr_wr_i && (sfr_addr_i == `ART_OFS_RELOAD_LO);
    assign wr_rl_hi = sfr_wr_i && (sfr_addr_i == `ART_OFS_RELOAD_HI);
    assign wr_cnt_lo = sfr_wr_i && (sfr_addr_i == `ART_OFS_COUNT_LO);
    assign wr_cnt_hi = sfr_wr_i && (sfr_addr_i == `ART_OFS_COUNT_HI);

    // ======================================================================
    // External oscillator path.
    // The oscillator is treated as an asynchronous pin and only its divided,
    // synchronised tick reaches the counter, so the counter stays in one domain.
    art_xosc_tick u_xosc_tick (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .xosc_i(xosc_i),
        .tick_o(xosc_tick)
    ); // R12 R13

    // ======================================================================
    // System clock prescaler.
    // The divide-by-twelve counter runs freely so that the first tick after
    // starting may come early by up to eleven cycles; this keeps it simple.
    always @* begin
        if (div12_ff == (`ART_SYS_DIV - 4'h1)) begin
            nxt_div12 = 4'h0;
        end else begin
            nxt_div12 = div12_ff + 4'h1;
        end
    end

    // Prescaler state.
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div12_ff <= 4'h0;
        end else begin
            div12_ff <= nxt_div12;
        end
    end

    // ======================================================================
    // Tick selection.
    // Only the system clock and the external oscillator feed the counter; there is no pin event input.
    always @* begin
        if (sysclk_divide_select_ff) begin
            sys_tick = 1'b1; // R3
        end else begin
            sys_tick = (div12_ff == (`ART_SYS_DIV - 4'h1)); // R3
        end
        if (external_clock_select_ff) begin
            timer_tick = run_control_ff && xosc_tick; // R2 R8 R10
        end else begin
            timer_tick = run_control_ff && sys_tick; // R3 R8 R10
        end
    end

    // ======================================================================
    // Counter next state.
    // A software write to a count byte wins over a tick in the same cycle,
    // so the written value is never lost to an increment.
    always @* begin
        rolls_over = timer_tick && (count_ff == `ART_COUNT_MAX); // R5
        nxt_count = count_ff;
        if (timer_tick) begin
            if (rolls_over) begin
                nxt_count = reload_ff; // R4 R14
            end else begin
                nxt_count = count_ff + 16'h0001; // R1
            end
        end
        if (wr_cnt_lo) begin
            nxt_count[7:0] = sfr_wdata_i; // R1
        end
        if (wr_cnt_hi) begin
            nxt_count[15:8] = sfr_wdata_i; // R1
        end
    end

    // ======================================================================
    // Overflow flag next state.
    // A roll-over in the same cycle as a software clear keeps the flag set.
    always @* begin
        nxt_overflow_flag = overflow_flag_ff;
        if (wr_ctrl) begin
            nxt_overflow_flag = sfr_wdata_i[`ART_BIT_OVF]; // R7
        end
        if (rolls_over) begin
            nxt_overflow_flag = 1'b1; // R5 R14
        end
    end

    // ======================================================================
    // Register file and counter state.
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            overflow_flag_ff <= `ART_RST_FLAG;
            run_control_ff <= 1'b0;
            sysclk_divide_select_ff <= 1'b0;
            external_clock_select_ff <= 1'b0;
            reload_ff <= `ART_RST_RELOAD;
            count_ff <= `ART_RST_COUNT;
        end else begin
            overflow_flag_ff <= nxt_overflow_flag;
            count_ff <= nxt_count;
            if (wr_ctrl) begin
                run_control_ff <= sfr_wdata_i[`ART_BIT_RUN]; // R8
                sysclk_divide_select_ff <= sfr_wdata_i[`ART_BIT_DIVSEL]; // R3
                external_clock_select_ff <= sfr_wdata_i[`ART_BIT_XCLK]; // R2
            end
            if (wr_rl_lo) begin
                reload_ff[7:0] <= sfr_wdata_i; // R14
            end
            if (wr_rl_hi) begin
                reload_ff[15:8] <= sfr_wdata_i; // R14
            end
        end
    end

    // ======================================================================
    // Read multiplexer.
    // Unused control bits and unmapped offsets read as zero.
    always @* begin
        case (sfr_addr_i)
            `ART_OFS_CTRL: begin
                rd_mux = {overflow_flag_ff, 4'h0, run_control_ff,
                          sysclk_divide_select_ff, external_clock_select_ff}; // R9
            end
            `ART_OFS_RELOAD_LO: begin
                rd_mux = reload_ff[7:0];
            end
            `ART_OFS_RELOAD_HI: begin
                rd_mux = reload_ff[15:8];
            end
            `ART_OFS_COUNT_LO: begin
                rd_mux = count_ff[7:0]; // R1
            end
            `ART_OFS_COUNT_HI: begin
                rd_mux = count_ff[15:8]; // R1
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // ======================================================================
    // Registered outputs.
    // Read data is captured one cycle after the read strobe and then held,
    // which keeps the bus path short at the cost of one cycle of latency.
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sfr_rdata_o <= 8'h00;
            irq_o <= 1'b0;
            overflow_pulse_o <= 1'b0;
        end else begin
            if (sfr_rd_i) begin
                sfr_rdata_o <= rd_mux;
            end
            irq_o <= nxt_overflow_flag && irq_enable_i; // R6
            overflow_pulse_o <= rolls_over; // R11
        end
    end

endmodule // art_timer

// >>> art_timer_sva.sv
// Concurrent checks on the ports of the auto-reload timer.
`timescale 1ns/1ps

`include "art_regs.vh"

// ==========================================================================
// Port checker
module art_timer_sva (
    input wire clk_sys_i,
    input wire rst_b_i,
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire [7:0] sfr_wdata_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_rdata_o,
    input wire irq_enable_i,
    input wire xosc_i,
    input wire irq_o,
    input wire overflow_pulse_o
);
    reg [2:0] ctrl_ff;
    wire ctl_wr = sfr_wr_i && (sfr_addr_i == `ART_OFS_CTRL);
    wire ctl_rd = sfr_rd_i && (sfr_addr_i == `ART_OFS_CTRL);

    // Shadow of the run and source bits, since the ports do not show them.
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_ff <= 3'h0;
        end else if (ctl_wr) begin
            ctrl_ff <= sfr_wdata_i[2:0];
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    irq_off_a: assert property (
        !irq_enable_i |=> !irq_o) else $error("irq high while disabled");
    irq_hold_a: assert property (
        irq_o && irq_enable_i && !ctl_wr |=> irq_o) else $error("irq dropped by itself");
    ovf_irq_a: assert property (
        overflow_pulse_o && $past(irq_enable_i) |-> irq_o) else $error("no irq on overflow");
    ctrl_zero_a: assert property (
        ctl_rd |=> sfr_rdata_o[6:3] == 4'h0) else $error("unused control bits not zero");
    rd_flag_a: assert property (
        ctl_rd && irq_o |=> sfr_rdata_o[7]) else $error("flag reads zero while set");
    rdata_hold_a: assert property (
        !sfr_rd_i |=> $stable(sfr_rdata_o)) else $error("read data moved without read");
    ovf_run_a: assert property (
        overflow_pulse_o |-> $past(ctrl_ff[2])) else $error("overflow while stopped");
    // Only the undivided system clock may overflow on adjacent cycles.
    ovf_spacing_a: assert property (
        overflow_pulse_o && (!$past(ctrl_ff[1]) || $past(ctrl_ff[0]))
        |=> !overflow_pulse_o [*8]) else $error("divided overflows too close");
endmodule // art_timer_sva

bind art_timer art_timer_sva chk_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o), .irq_enable_i(irq_enable_i),
    .xosc_i(xosc_i), .irq_o(irq_o), .overflow_pulse_o(overflow_pulse_o));

// >>> testbench.sv
// Self-checking bench for the auto-reload timer.
`timescale 1ns/1ps

`include "art_regs.vh"

// ==========================================================================
// Bench top
module testbench;
    reg clk_sys_i, rst_b_i, sfr_wr_i, sfr_rd_i, irq_enable_i, xosc_i;
    reg [7:0] sfr_addr_i, sfr_wdata_i, rv;
    wire [7:0] sfr_rdata_o;
    wire irq_o, overflow_pulse_o;
    integer miscompares, checks, i, n;

    art_timer dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i),
        .sfr_rdata_o(sfr_rdata_o), .irq_enable_i(irq_enable_i), .xosc_i(xosc_i),
        .irq_o(irq_o), .overflow_pulse_o(overflow_pulse_o));

    // System clock, and an oscillator whose edges never meet a clock edge.
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        xosc_i = 1'b0;
        #3;
        forever #40 xosc_i = ~xosc_i;
    end

    task check(input string name, input [15:0] got, input [15:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task tally_and_finish;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Each access takes two cycles, so no strobe is raised and lowered at one time.
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk_sys_i); #1;
        sfr_addr_i = a; sfr_wdata_i = d; sfr_wr_i = 1'b1;
        @(posedge clk_sys_i); #1;
        sfr_wr_i = 1'b0;
    endtask

    task rd(input [7:0] a);
        @(posedge clk_sys_i); #1;
        sfr_addr_i = a; sfr_rd_i = 1'b1;
        @(posedge clk_sys_i); #1;
        sfr_rd_i = 1'b0;
        rv = sfr_rdata_o;
    endtask

    // Bounded wait for the overflow event; a hang closes the run.
    task wait_pulse;
        n = 0;
        while (overflow_pulse_o !== 1'b1) begin
            if (n == 400) begin
                miscompares = miscompares + 1;
                tally_and_finish;
            end
            @(posedge clk_sys_i); #1;
            n = n + 1;
        end
    endtask

    task t_reset;
        wr(8'h96, 8'hFF);
        for (i = 8'h91; i <= 8'h96; i = i + 1) begin
            rd(i[7:0]);
            check("reset value", rv, 16'h0000);
        end
    endtask

    task t_regs;
        wr(`ART_OFS_CTRL, 8'h78);
        rd(`ART_OFS_CTRL);
        check("control unused", rv, 16'h0000);
        wr(`ART_OFS_COUNT_LO, 8'h34);
        wr(`ART_OFS_COUNT_HI, 8'h12);
        rd(`ART_OFS_COUNT_LO);
        check("count low", rv, 16'h0034);
        repeat (20) @(posedge clk_sys_i);
        rd(`ART_OFS_COUNT_LO);
        check("stopped count", rv, 16'h0034);
        rd(`ART_OFS_COUNT_HI);
        check("count high", rv, 16'h0012);
    endtask

    // Reload of all ones overflows every tick, so the count must sit at all ones.
    task t_ovf;
        irq_enable_i = 1'b1;
        wr(`ART_OFS_RELOAD_LO, 8'hFF);
        wr(`ART_OFS_RELOAD_HI, 8'hFF);
        wr(`ART_OFS_COUNT_LO, 8'hFE);
        wr(`ART_OFS_COUNT_HI, 8'hFF);
        wr(`ART_OFS_CTRL, 8'h06);
        wait_pulse;
        check("irq on overflow", irq_o, 16'h0001);
        rd(`ART_OFS_CTRL);
        check("flag by hardware", rv, 16'h0086);
        wr(`ART_OFS_CTRL, 8'h82);
        rd(`ART_OFS_COUNT_LO);
        check("reloaded count", rv, 16'h00FF);
        rd(`ART_OFS_CTRL);
        check("flag set", rv, 16'h0082);
        irq_enable_i = 1'b0;
        @(posedge clk_sys_i); #1;
        check("irq masked", irq_o, 16'h0000);
        irq_enable_i = 1'b1;
        @(posedge clk_sys_i); #1;
        check("flag sticky", irq_o, 16'h0001);
        wr(`ART_OFS_CTRL, 8'h00);
        rd(`ART_OFS_CTRL);
        check("flag cleared", rv, 16'h0000);
    endtask

    // Two ticks per overflow; the gap between events shows the tick rate.
    task t_period(input [7:0] mode, input [15:0] exp);
        wr(`ART_OFS_CTRL, 8'h00);
        wr(`ART_OFS_RELOAD_LO, 8'hFE);
        rd(`ART_OFS_RELOAD_LO);
        check("reload low", rv, 16'h00FE);
        wr(`ART_OFS_COUNT_LO, 8'hFF);
        wr(`ART_OFS_CTRL, mode);
        wait_pulse;
        @(posedge clk_sys_i); #1;
        wait_pulse;
        check("overflow gap", n + 1, exp);
    endtask

    initial begin
        miscompares = 0;
        checks = 0;
        rst_b_i = 1'b0;
        sfr_wr_i = 1'b0;
        sfr_rd_i = 1'b0;
        sfr_addr_i = 8'h00;
        sfr_wdata_i = 8'h00;
        irq_enable_i = 1'b0;
        repeat (12) @(posedge clk_sys_i);
        #1 rst_b_i = 1'b1;
        t_reset;
        t_regs;
        t_ovf;
        t_period(8'h06, 16'd2);
        t_period(8'h04, 16'd24);
        t_period(8'h05, 16'd160);
        t_period(8'h07, 16'd160);
        wr(`ART_OFS_CTRL, 8'h00);
        tally_and_finish;
    end
endmodule // testbench
